// *** design/oad_decode.v ***
// operand addressing decoder with fetch throughput model
`timescale 1ns/1ps
`default_nettype none
`include "oad_map.vh"
module oad_decode (
  // clock and reset
  input wire clk_sys,
  input wire nrst,
  // operand request
  input wire req_valid,
  input wire [4:0] req_mode,
  input wire [23:0] req_field,
  input wire [23:0] req_pc_next,
  input wire [1:0] req_bank,
  input wire [31:0] req_ptr,
  input wire [15:0] req_disp,
  // operand answer
  output reg res_valid_q,
  output reg [23:0] res_addr_q,
  output reg [1:0] res_space_q,
  output reg [2:0] res_bit_q,
  output reg [5:0] res_reg_q,
  output reg [31:0] res_const_q,
  output reg res_illegal_q,
  // code memory side
  input wire mem_valid,
  input wire mem_wide,
  input wire [15:0] mem_data,
  output wire mem_ready_q,
  // code byte stream to core
  output wire byte_valid_q,
  output wire [7:0] byte_data_q,
  input wire byte_ready,
  // state timing and throughput
  output wire state_tick_q,
  input wire [2:0] avg_size,
  input wire page_mode,
  input wire [2:0] wait_states,
  input wire [7:0] exec_states,
  output wire [7:0] eff_states_q
);
  // ---------------------------------------------------------------
  // fetch model
  // ---------------------------------------------------------------
  oad_fetch u_fetch (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .mem_valid(mem_valid),
    .mem_wide(mem_wide),
    .mem_data(mem_data),
    .mem_ready_q(mem_ready_q),
    .byte_valid_q(byte_valid_q),
    .byte_data_q(byte_data_q),
    .byte_ready(byte_ready),
    .state_tick_q(state_tick_q),
    .avg_size(avg_size),
    .page_mode(page_mode),
    .wait_states(wait_states),
    .exec_states(exec_states),
    .eff_states_q(eff_states_q)
  );
  // ---------------------------------------------------------------
  // shared terms
  // ---------------------------------------------------------------
  wire [23:0] rel_ext = {{16{req_field[7]}}, req_field[7:0]};
  wire [23:0] disp_ext = {{8{req_disp[15]}}, req_disp};
  wire [7:0] lbit_num = req_field[7:0];
  wire [7:0] xbit_byte = req_field[10:3];
  wire [5:0] dreg_idx = req_field[5:0];
  wire [4:0] wreg_idx = req_field[4:0];
  wire dreg_ok;
  wire wreg_ok;
  // only 4-aligned low indices and the two stack-side entries exist
  assign dreg_ok = (dreg_idx[1:0] == 2'h0) && ((dreg_idx <= `OAD_DREG_MAX) ||
    (dreg_idx == `OAD_DREG_HI0) || (dreg_idx == `OAD_DREG_HI1)) &&
    (req_field[23:6] == 18'h00000);
  assign wreg_ok = (wreg_idx[0] == 1'b0) && (wreg_idx <= `OAD_WREG_MAX) &&
    (req_field[23:5] == 19'h00000);
  // legality of the short register forms
  wire lind_ok = (req_field[2:1] == 2'h0);
  wire breg_ok = (req_field[7:3] == 5'h00);
  wire freg_ok = (req_field[7:4] == 4'h0);
  // ---------------------------------------------------------------
  // operand targets
  // ---------------------------------------------------------------
  // sums wrap at their own width; no carry leaves the region or the space
  wire [23:0] rel_target = req_pc_next + rel_ext;
  wire [23:0] blk_target = {req_pc_next[23:11], req_field[10:0]};
  wire [23:0] rgn_target = {req_pc_next[23:16], req_field[15:0]};
  wire [15:0] wdsp_sum = req_ptr[15:0] + req_disp;
  wire [23:0] ddsp_sum = req_ptr[23:0] + disp_ext;
  wire [7:0] lbit_ram_byte = `OAD_BIT_RAM_BASE + {4'h0, lbit_num[6:3]};
  wire [7:0] lbit_sfr_byte = {lbit_num[7:3], 3'h0};
  // immediate constants, widened here once for every form except the small IMMS constants set in the decode
  wire [31:0] imm_byte = {24'h000000, req_field[7:0]};
  wire [31:0] imm_word = {16'h0000, req_field[15:0]};
  wire [31:0] imm_zero_extended = {16'h0000, req_field[15:0]};
  wire [31:0] imm_one_extended = {16'hFFFF, req_field[15:0]};
  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  reg [23:0] addr_d;
  reg [1:0] space_d;
  reg [2:0] bit_d;
  reg [5:0] reg_d;
  reg [31:0] const_d;
  reg illegal_d;
  always @* begin
    addr_d = 24'h000000;
    space_d = `OAD_SP_NONE;
    bit_d = 3'h0;
    reg_d = 6'h00;
    const_d = 32'h00000000;
    illegal_d = 1'b0;
    case (req_mode)
      `OAD_M_SDIR: begin
        addr_d = {16'h0000, req_field[7:0]};
        space_d = req_field[7] ? `OAD_SP_SFR : `OAD_SP_IRAM;
      end
      `OAD_M_LDIR: begin
        addr_d = {8'h00, req_field[15:0]};
        space_d = `OAD_SP_MEM;
      end
      `OAD_M_IMM8: begin
        const_d = imm_byte;
      end
      `OAD_M_IMMW: begin
        const_d = imm_word;
      end
      `OAD_M_IMMZ: begin
        const_d = imm_zero_extended;
      end
      `OAD_M_IMMO: begin
        const_d = imm_one_extended;
      end
      `OAD_M_IMMS: begin
        case (req_field[1:0])
          2'h0: begin
            const_d = 32'h00000001;
          end
          2'h1: begin
            const_d = 32'h00000002;
          end
          2'h2: begin
            const_d = 32'h00000004;
          end
          default: begin
            illegal_d = 1'b1;
          end
        endcase
      end
      `OAD_M_LBIT: begin
        bit_d = lbit_num[2:0];
        if (!lbit_num[7]) begin
          addr_d = {16'h0000, lbit_ram_byte};
          space_d = `OAD_SP_IRAM;
        end else begin
          addr_d = {16'h0000, lbit_sfr_byte};
          space_d = `OAD_SP_SFR;
        end
      end
      `OAD_M_XBIT: begin
        // defined special registers are not known here; the whole upper half passes
        bit_d = req_field[2:0];
        addr_d = {16'h0000, xbit_byte};
        if (xbit_byte[7]) begin
          space_d = `OAD_SP_SFR;
        end else if (xbit_byte >= `OAD_XBIT_LO) begin
          space_d = `OAD_SP_IRAM;
        end else begin
          illegal_d = 1'b1;
        end
      end
      `OAD_M_REL: begin
        addr_d = rel_target;
        space_d = `OAD_SP_MEM;
      end
      `OAD_M_BLK: begin
        addr_d = blk_target;
        space_d = `OAD_SP_MEM;
      end
      `OAD_M_RGN: begin
        addr_d = rgn_target;
        space_d = `OAD_SP_MEM;
      end
      `OAD_M_FULL: begin
        addr_d = req_field;
        space_d = `OAD_SP_MEM;
      end
      `OAD_M_LIND: begin
        reg_d = {1'b0, req_bank, 2'h0, req_field[0]};
        addr_d = {16'h0000, req_ptr[7:0]};
        space_d = `OAD_SP_IRAM;
        illegal_d = !lind_ok;
      end
      `OAD_M_BREG: begin
        reg_d = {1'b0, req_bank, req_field[2:0]};
        illegal_d = !breg_ok;
      end
      `OAD_M_FREG: begin
        reg_d = {2'h0, req_field[3:0]};
        illegal_d = !freg_ok;
      end
      `OAD_M_WREG: begin
        reg_d = {1'b0, wreg_idx};
        illegal_d = !wreg_ok;
      end
      `OAD_M_WIND: begin
        reg_d = {1'b0, wreg_idx};
        addr_d = {8'h00, req_ptr[15:0]};
        space_d = `OAD_SP_MEM;
        illegal_d = !wreg_ok;
      end
      `OAD_M_WDSP: begin
        // the sum wraps inside the first region, no carry into bank bits
        reg_d = {1'b0, wreg_idx};
        addr_d = {8'h00, wdsp_sum};
        space_d = `OAD_SP_MEM;
        illegal_d = !wreg_ok;
      end
      `OAD_M_DREG: begin
        reg_d = dreg_idx;
        illegal_d = !dreg_ok;
      end
      `OAD_M_DIND: begin
        reg_d = dreg_idx;
        addr_d = req_ptr[23:0];
        space_d = `OAD_SP_MEM;
        illegal_d = !dreg_ok;
      end
      `OAD_M_DDSP: begin
        reg_d = dreg_idx;
        addr_d = ddsp_sum;
        space_d = `OAD_SP_MEM;
        illegal_d = !dreg_ok;
      end
      default: begin
        illegal_d = 1'b1;
      end
    endcase
    // illegal forms never point anywhere
    if (illegal_d) begin
      space_d = `OAD_SP_NONE;
    end
  end
  // ---------------------------------------------------------------
  // answer strobe
  // ---------------------------------------------------------------
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      res_valid_q <= 1'b0;
    end else begin
      res_valid_q <= req_valid;
    end
  end
  // ---------------------------------------------------------------
  // answer register
  // ---------------------------------------------------------------
  // fields hold between requests so the core may read them late
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      res_addr_q <= 24'h000000;
      res_space_q <= `OAD_SP_NONE;
      res_bit_q <= 3'h0;
      res_reg_q <= 6'h00;
      res_const_q <= 32'h00000000;
      res_illegal_q <= 1'b0;
    end else begin
      if (req_valid) begin
        res_addr_q <= addr_d;
        res_space_q <= space_d;
        res_bit_q <= bit_d;
        res_reg_q <= reg_d;
        res_const_q <= const_d;
        res_illegal_q <= illegal_d;
      end
    end
  end
endmodule // oad_decode
`default_nettype wire

// *** design/oad_fetch.v ***
// prefetch queue, state tick and fetch-limited throughput
`timescale 1ns/1ps
`default_nettype none
`include "oad_map.vh"
module oad_fetch (
  // clock and reset
  input wire clk_sys,
  input wire nrst,
  // code memory side
  input wire mem_valid,
  input wire mem_wide,
  input wire [15:0] mem_data,
  output reg mem_ready_q,
  // core side
  output reg byte_valid_q,
  output wire [7:0] byte_data_q,
  input wire byte_ready,
  // state timing
  output reg state_tick_q,
  // throughput estimate
  input wire [2:0] avg_size,
  input wire page_mode,
  input wire [2:0] wait_states,
  input wire [7:0] exec_states,
  output reg [7:0] eff_states_q
);
  // ---------------------------------------------------------------
  // state tick
  // ---------------------------------------------------------------
  reg [1:0] st_cnt_q;
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_cnt_q <= 2'h0;
      state_tick_q <= 1'b0;
    end else if (st_cnt_q == (`OAD_STATE_CYCLES - 1)) begin
      st_cnt_q <= 2'h0;
      state_tick_q <= 1'b1;
    end else begin
      st_cnt_q <= st_cnt_q + 2'h1;
      state_tick_q <= 1'b0;
    end
  end
  // ---------------------------------------------------------------
  // prefetch queue
  // ---------------------------------------------------------------
  // shift queue so the head byte is always entry zero, a plain flop
  reg [7:0] q_q [0:`OAD_Q_DEPTH];
  reg [`OAD_Q_CNT_W-1:0] cnt_q;
  wire pop = byte_valid_q & byte_ready;
  wire push = mem_valid & mem_ready_q;
  wire [`OAD_Q_CNT_W-1:0] cnt_pop = cnt_q - {2'h0, pop};
  wire [`OAD_Q_CNT_W-1:0] cnt_d = cnt_pop + (push ? (mem_wide ? 3'h2 : 3'h1) : 3'h0);
  assign byte_data_q = q_q[0];
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      q_q[`OAD_Q_DEPTH] <= 8'h00;
    end else begin
      q_q[`OAD_Q_DEPTH] <= 8'h00;
    end
  end
  genvar gi;
  generate
    for (gi = 0; gi < `OAD_Q_DEPTH; gi = gi + 1) begin : g_ent
      always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
          q_q[gi] <= 8'h00;
        end else if (push && cnt_pop == gi) begin
          q_q[gi] <= mem_data[7:0];
        end else if (push && mem_wide && cnt_pop + 3'h1 == gi) begin
          q_q[gi] <= mem_data[15:8];
        end else if (pop) begin
          q_q[gi] <= q_q[gi+1];
        end
      end
    end
  endgenerate
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 3'h0;
      byte_valid_q <= 1'b0;
      mem_ready_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      byte_valid_q <= (cnt_d != 3'h0);
      // room kept for a full 16-bit word, stalls memory when core is slow
      mem_ready_q <= (cnt_d <= `OAD_Q_ROOM);
    end
  end
  // ---------------------------------------------------------------
  // throughput bound
  // ---------------------------------------------------------------
  reg [7:0] ws_c;
  reg [7:0] fetch_min;
  always @* begin
    ws_c = (wait_states > `OAD_WS_MAX) ? {5'h00, `OAD_WS_MAX} : {5'h00, wait_states};
    if (page_mode) begin
      fetch_min = {5'h00, avg_size};
    end else begin
      fetch_min = {5'h00, avg_size} * (ws_c + `OAD_FETCH_BASE);
    end
  end
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      eff_states_q <= 8'h00;
    end else begin
      eff_states_q <= (exec_states > fetch_min) ? exec_states : fetch_min;
    end
  end
endmodule // oad_fetch
`default_nettype wire

// *** design/oad_map.vh ***
// constants for the operand addressing decoder and fetch model
`ifndef OAD_MAP_VH
`define OAD_MAP_VH
// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define OAD_CLK_NS 20
`define OAD_STATE_NS 40
`define OAD_STATE_CYCLES (`OAD_STATE_NS / `OAD_CLK_NS)
// ---------------------------------------------------------------
// operand forms
// ---------------------------------------------------------------
`define OAD_M_SDIR 5'h00
`define OAD_M_LDIR 5'h01
`define OAD_M_IMM8 5'h02
`define OAD_M_IMMW 5'h03
`define OAD_M_IMMZ 5'h04
`define OAD_M_IMMO 5'h05
`define OAD_M_IMMS 5'h06
`define OAD_M_LBIT 5'h07
`define OAD_M_XBIT 5'h08
`define OAD_M_REL 5'h09
`define OAD_M_BLK 5'h0A
`define OAD_M_RGN 5'h0B
`define OAD_M_FULL 5'h0C
`define OAD_M_LIND 5'h0D
`define OAD_M_BREG 5'h0E
`define OAD_M_FREG 5'h0F
`define OAD_M_WREG 5'h10
`define OAD_M_WIND 5'h11
`define OAD_M_WDSP 5'h12
`define OAD_M_DREG 5'h13
`define OAD_M_DIND 5'h14
`define OAD_M_DDSP 5'h15
// ---------------------------------------------------------------
// target spaces
// ---------------------------------------------------------------
`define OAD_SP_NONE 2'h0
`define OAD_SP_IRAM 2'h1
`define OAD_SP_SFR 2'h2
`define OAD_SP_MEM 2'h3
// ---------------------------------------------------------------
// address figures
// ---------------------------------------------------------------
`define OAD_BIT_RAM_BASE 8'h20
`define OAD_XBIT_LO 8'h20
`define OAD_DREG_MAX 6'h1C
`define OAD_DREG_HI0 6'h38
`define OAD_DREG_HI1 6'h3C
`define OAD_WREG_MAX 5'h1E
// ---------------------------------------------------------------
// fetch model
// ---------------------------------------------------------------
`define OAD_Q_DEPTH 4
`define OAD_Q_CNT_W 3
`define OAD_Q_ROOM 3'h2
`define OAD_WS_MAX 3'h4
`define OAD_FETCH_BASE 8'h02
`endif

// *** dv/oad_checker.sv ***
// assertion checker on the operand decoder top ports
`timescale 1ns/1ps
`default_nettype none
`include "oad_map.vh"
module oad_checker (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // request and answer
  input wire logic req_valid,
  input wire logic [4:0] req_mode,
  input wire logic [23:0] req_field,
  input wire logic [23:0] req_pc_next,
  input wire logic [23:0] res_addr_q,
  input wire logic [1:0] res_space_q,
  input wire logic [31:0] res_const_q,
  // timing and throughput
  input wire logic state_tick_q,
  input wire logic [7:0] exec_states,
  input wire logic [7:0] eff_states_q
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // ----
  // assertions
  // ----
  AST_TICK: assert property (state_tick_q |=> !state_tick_q ##1 state_tick_q)
    else $error("state tick not every second clock");
  // guard on past reset: first edge after release still sees reset inputs
  AST_EFF_MAX: assert property ($past(nrst) |-> eff_states_q >= $past(exec_states))
    else $error("effective time below execution time");
  AST_SDIR: assert property (
    req_valid && req_mode == `OAD_M_SDIR |=>
    res_space_q == ($past(req_field[7]) ? `OAD_SP_SFR : `OAD_SP_IRAM))
    else $error("short direct space wrong");
  AST_LDIR: assert property (
    req_valid && req_mode == `OAD_M_LDIR |=> res_addr_q == {8'h00, $past(req_field[15:0])})
    else $error("long direct address wrong");
  AST_IMMO: assert property (
    req_valid && req_mode == `OAD_M_IMMO |=> res_const_q == {16'hFFFF, $past(req_field[15:0])})
    else $error("one filled constant wrong");
  AST_REL: assert property (
    req_valid && req_mode == `OAD_M_REL |=> res_addr_q ==
    $past(req_pc_next) + {{16{$past(req_field[7])}}, $past(req_field[7:0])})
    else $error("relative target wrong");
  AST_BLK: assert property (
    req_valid && req_mode == `OAD_M_BLK |=>
    res_addr_q == {$past(req_pc_next[23:11]), $past(req_field[10:0])})
    else $error("block target wrong");
  AST_FULL: assert property (
    req_valid && req_mode == `OAD_M_FULL |=> res_addr_q == $past(req_field))
    else $error("full target wrong");
  COV_REL: cover property (req_valid && req_mode == `OAD_M_REL);
  COV_FETCH_LIM: cover property (eff_states_q > exec_states);
  COV_TICK: cover property (state_tick_q ##2 state_tick_q);
endmodule // oad_checker
bind oad_decode oad_checker i_oad_checker (.clk_sys(clk_sys), .nrst(nrst),
  .req_valid(req_valid), .req_mode(req_mode), .req_field(req_field),
  .req_pc_next(req_pc_next), .res_addr_q(res_addr_q), .res_space_q(res_space_q),
  .res_const_q(res_const_q), .state_tick_q(state_tick_q), .exec_states(exec_states),
  .eff_states_q(eff_states_q));
`default_nettype wire

// *** dv/oad_codemem.sv ***
// code memory model offering bytes to the prefetch queue
`timescale 1ns/1ps
`default_nettype none
module oad_codemem (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // bench control
  input wire logic en,
  input wire logic wide,
  input wire logic slow,
  // queue side
  input wire logic mem_ready_q,
  output logic mem_valid,
  output logic mem_wide,
  output logic [15:0] mem_data
);
  logic [7:0] ptr_q;
  logic ph_q;
  logic [15:0] word;
  assign word = {ptr_q + 8'h41, ptr_q + 8'h40};
  // slow memory rests a cycle after each taken offer, then holds it until taken
  assign mem_valid = en & (~slow | ph_q);
  assign mem_wide = wide;
  // released bus shows inverted data, never a stale copy
  assign mem_data = mem_valid ? word : ~word;
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ptr_q <= 8'h00;
      ph_q <= 1'h0;
    end else begin
      ph_q <= ~(mem_valid & mem_ready_q);
      if (mem_valid && mem_ready_q) ptr_q <= ptr_q + (wide ? 8'h02 : 8'h01);
    end
  end
endmodule // oad_codemem
`default_nettype wire

// *** dv/testbench.sv ***
// self-checking bench for the operand decoder and fetch model
`timescale 1ns/1ps
`default_nettype none
`include "oad_map.vh"
module testbench;
  logic clk_sys = 1'h0, nrst = 1'h0, req_valid = 1'h0, byte_ready = 1'h0, page_mode = 1'h0;
  logic en = 1'h0, wide = 1'h0, slow = 1'h0;
  logic [4:0] req_mode = 5'h00;
  logic [23:0] req_field = 24'h000000, req_pc_next = 24'h000000;
  logic [1:0] req_bank = 2'h0;
  logic [31:0] req_ptr = 32'h00000000;
  logic [15:0] req_disp = 16'h0000;
  logic [2:0] avg_size = 3'h1, wait_states = 3'h0;
  logic [7:0] exec_states = 8'h00, exp_b = 8'h40;
  wire res_valid_q, res_illegal_q, mem_valid, mem_wide, mem_ready_q, byte_valid_q, state_tick_q;
  wire [23:0] res_addr_q;
  wire [1:0] res_space_q;
  wire [2:0] res_bit_q;
  wire [5:0] res_reg_q;
  wire [31:0] res_const_q;
  wire [15:0] mem_data;
  wire [7:0] byte_data_q, eff_states_q;
  int miscompares = 0, n_compared = 0;
  always #10 clk_sys = ~clk_sys;
  oad_decode i_oad_decode (.clk_sys(clk_sys), .nrst(nrst), .req_valid(req_valid),
    .req_mode(req_mode), .req_field(req_field), .req_pc_next(req_pc_next),
    .req_bank(req_bank), .req_ptr(req_ptr), .req_disp(req_disp), .res_valid_q(res_valid_q),
    .res_addr_q(res_addr_q), .res_space_q(res_space_q), .res_bit_q(res_bit_q),
    .res_reg_q(res_reg_q), .res_const_q(res_const_q), .res_illegal_q(res_illegal_q),
    .mem_valid(mem_valid), .mem_wide(mem_wide), .mem_data(mem_data),
    .mem_ready_q(mem_ready_q), .byte_valid_q(byte_valid_q), .byte_data_q(byte_data_q),
    .byte_ready(byte_ready), .state_tick_q(state_tick_q), .avg_size(avg_size),
    .page_mode(page_mode), .wait_states(wait_states), .exec_states(exec_states),
    .eff_states_q(eff_states_q));
  oad_codemem i_oad_codemem (.clk_sys(clk_sys), .nrst(nrst), .en(en), .wide(wide),
    .slow(slow), .mem_ready_q(mem_ready_q), .mem_valid(mem_valid), .mem_wide(mem_wide),
    .mem_data(mem_data));
  // ----
  // helpers
  // ----
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic close_out;
    if (miscompares == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic dec(input logic [4:0] m, input logic [23:0] f, input logic [31:0] p);
    @(posedge clk_sys);
    req_valid <= 1'h1;
    req_mode <= m;
    req_field <= f;
    req_ptr <= p;
    @(posedge clk_sys);
    req_valid <= 1'h0;
    @(negedge clk_sys);
    chk(res_valid_q, 1'h1);
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_direct;
    dec(`OAD_M_SDIR, 24'h00007F, 32'h0);
    chk(res_space_q, `OAD_SP_IRAM);
    dec(`OAD_M_SDIR, 24'h000080, 32'h0);
    chk(res_space_q, `OAD_SP_SFR);
    dec(`OAD_M_LDIR, 24'h05FFFF, 32'h0);
    chk(res_addr_q, 24'h00FFFF);
  endtask
  task automatic t_imm;
    dec(`OAD_M_IMM8, 24'h1234A5, 32'h0);
    chk(res_const_q, 32'h000000A5);
    dec(`OAD_M_IMMW, 24'h12BEEF, 32'h0);
    chk(res_const_q, 32'h0000BEEF);
    dec(`OAD_M_IMMZ, 24'h008001, 32'h0);
    chk(res_const_q, 32'h00008001);
    dec(`OAD_M_IMMO, 24'h008001, 32'h0);
    chk(res_const_q, 32'hFFFF8001);
    for (int i = 0; i < 4; i++) begin
      dec(`OAD_M_IMMS, i[23:0], 32'h0);
      chk(res_illegal_q, i == 3);
      if (i < 3) chk(res_const_q, 32'h1 << i);
    end
  endtask
  task automatic t_bits;
    dec(`OAD_M_LBIT, 24'h000000, 32'h0);
    chk({res_space_q, res_addr_q, res_bit_q}, {`OAD_SP_IRAM, 24'h000020, 3'h0});
    dec(`OAD_M_LBIT, 24'h00007F, 32'h0);
    chk({res_space_q, res_addr_q, res_bit_q}, {`OAD_SP_IRAM, 24'h00002F, 3'h7});
    dec(`OAD_M_LBIT, 24'h000081, 32'h0);
    chk({res_space_q, res_addr_q, res_bit_q}, {`OAD_SP_SFR, 24'h000080, 3'h1});
    dec(`OAD_M_LBIT, 24'h0000FF, 32'h0);
    chk({res_space_q, res_addr_q, res_bit_q}, {`OAD_SP_SFR, 24'h0000F8, 3'h7});
    dec(`OAD_M_XBIT, 24'h000103, 32'h0);
    chk({res_space_q, res_addr_q, res_bit_q}, {`OAD_SP_IRAM, 24'h000020, 3'h3});
    dec(`OAD_M_XBIT, 24'h0003FF, 32'h0);
    chk({res_space_q, res_addr_q, res_bit_q}, {`OAD_SP_IRAM, 24'h00007F, 3'h7});
    dec(`OAD_M_XBIT, 24'h000482, 32'h0);
    chk({res_space_q, res_addr_q, res_bit_q}, {`OAD_SP_SFR, 24'h000090, 3'h2});
    dec(`OAD_M_XBIT, 24'h0000F8, 32'h0);
    chk({res_illegal_q, res_space_q}, 3'h4);
  endtask
  task automatic t_branch;
    @(posedge clk_sys) req_pc_next <= 24'h123456;
    dec(`OAD_M_REL, 24'h000080, 32'h0);
    chk(res_addr_q, 24'h1233D6);
    dec(`OAD_M_REL, 24'h00007F, 32'h0);
    chk(res_addr_q, 24'h1234D5);
    dec(`OAD_M_BLK, 24'h0007FF, 32'h0);
    chk(res_addr_q, 24'h1237FF);
    dec(`OAD_M_BLK, 24'h000000, 32'h0);
    chk(res_addr_q, 24'h123000);
    dec(`OAD_M_RGN, 24'h99ABCD, 32'h0);
    chk(res_addr_q, 24'h12ABCD);
    dec(`OAD_M_FULL, 24'hFEDCBA, 32'h0);
    chk(res_addr_q, 24'hFEDCBA);
    @(posedge clk_sys) req_pc_next <= 24'h000010;
    dec(`OAD_M_REL, 24'h000080, 32'h0);
    chk(res_addr_q, 24'hFFFF90);
  endtask
  task automatic t_regs;
    @(posedge clk_sys) req_bank <= 2'h2;
    dec(`OAD_M_LIND, 24'h000001, 32'h000000C3);
    chk({res_illegal_q, res_reg_q, res_addr_q}, {1'h0, 6'h11, 24'h0000C3});
    dec(`OAD_M_LIND, 24'h000002, 32'h0);
    chk(res_illegal_q, 1'h1);
    dec(`OAD_M_BREG, 24'h000007, 32'h0);
    chk({res_illegal_q, res_reg_q}, 7'h17);
    dec(`OAD_M_BREG, 24'h000008, 32'h0);
    chk(res_illegal_q, 1'h1);
    dec(`OAD_M_FREG, 24'h00000F, 32'h0);
    chk({res_illegal_q, res_reg_q}, 7'h0F);
    dec(`OAD_M_FREG, 24'h000010, 32'h0);
    chk(res_illegal_q, 1'h1);
    dec(`OAD_M_WREG, 24'h00001E, 32'h0);
    chk({res_illegal_q, res_reg_q}, 7'h1E);
    dec(`OAD_M_WREG, 24'h00001F, 32'h0);
    chk(res_illegal_q, 1'h1);
    dec(`OAD_M_WIND, 24'h000000, 32'h1234FFFF);
    chk(res_addr_q, 24'h00FFFF);
    @(posedge clk_sys) req_disp <= 16'hFFF0;
    dec(`OAD_M_WDSP, 24'h000000, 32'h00000005);
    chk(res_addr_q, 24'h00FFF5);
    dec(`OAD_M_DDSP, 24'h000000, 32'h00000100);
    chk(res_addr_q, 24'h0000F0);
    dec(`OAD_M_DIND, 24'h000000, 32'h12FEDCBA);
    chk(res_addr_q, 24'hFEDCBA);
    for (int k = 0; k < 64; k++) begin
      dec(`OAD_M_DREG, k[23:0], 32'h0);
      chk(res_illegal_q, !((k % 4 == 0 && k <= 28) || k == 56 || k == 60));
    end
  endtask
  task automatic t_tput;
    int e;
    for (int pm = 0; pm < 2; pm++)
      for (int ws = 0; ws < 6; ws++)
        for (int sz = 1; sz < 6; sz++) begin
          e = pm ? sz : sz * (2 + (ws > 4 ? 4 : ws));
          @(posedge clk_sys);
          page_mode <= pm[0];
          wait_states <= ws[2:0];
          avg_size <= sz[2:0];
          exec_states <= 8'h03;
          @(posedge clk_sys);
          @(negedge clk_sys);
          chk(eff_states_q, e > 3 ? e : 3);
        end
  endtask
  // tick must alternate every clock: one state is two clocks
  task automatic t_tick;
    logic prev;
    @(negedge clk_sys);
    prev = state_tick_q;
    repeat (8) begin
      @(negedge clk_sys);
      chk(state_tick_q, !prev);
      prev = state_tick_q;
    end
  endtask
  // core stalls first so the queue must refuse further offers
  task automatic t_fetch(input logic w, input logic s);
    @(posedge clk_sys);
    wide <= w;
    slow <= s;
    en <= 1'h1;
    byte_ready <= 1'h0;
    repeat (12) @(posedge clk_sys);
    @(negedge clk_sys);
    chk({mem_ready_q, byte_valid_q}, 2'h1);
    for (int c = 0; c < 40; c++) begin
      @(posedge clk_sys);
      if (c == 20) en <= 1'h0;
      byte_ready <= c[0] | w;
      @(negedge clk_sys);
      if (byte_valid_q && byte_ready) begin
        chk(byte_data_q, exp_b);
        exp_b++;
      end
    end
    chk(byte_valid_q, 1'h0);
  endtask
  initial begin
    repeat (8) @(posedge clk_sys);
    nrst <= 1'h1;
    t_direct;
    t_imm;
    t_bits;
    t_branch;
    t_regs;
    t_tput;
    t_tick;
    t_fetch(1'h1, 1'h0);
    t_fetch(1'h0, 1'h1);
    close_out;
  end
  initial begin
    #200000;
    miscompares++;
    close_out;
  end
endmodule // testbench
`default_nettype wire
